// File: sct_params.svh
// timing counts and constants of the slow-clock timer block
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
`define SCT_SLOW_CLK_HZ     32000
`define SCT_AUTORESUME_CYC  918
`define SCT_ID_DEB_CYC      56
`define SCT_ID_MASK_CYC     1136
`define SCT_VBUS_DEB_CYC    459
`define SCT_IDP_ON_CYC      8
`define SCT_VDP_ON_CYC      1792
`define SCT_HICRNT_CYC      1792
`define SCT_DCD_CYC         89400
`define SCT_WKB_CYC         53084160
`define SCT_VDM_DEB_CYC     760
`define SCT_SERX_DEB_CYC    1520
`define SCT_ACA_DEB_CYC     1520
`define SCT_ACA_SETUP_CYC   2300
`define SCT_RXCMD_ID_BIT    6
`define SCT_CNT_W           26
`endif

// File: sct_pkg.sv
// types of the slow-clock timer block
package sct_pkg;
	typedef enum logic [1:0] {SCT_OFF, SCT_STANDARD, SCT_CHARGER} sct_pwr_t;
endpackage : sct_pkg

// File: sct_counter.sv
// generic debounce or one-shot counter on the slow clock
`include "sct_params.svh"
module sct_counter #(
	parameter int               W     = `SCT_CNT_W,
	parameter logic [W-1:0]     LIMIT = W'(1),
	parameter bit               DEB   = 1'b0
) (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           adv,
	input  wire logic           in,
	input  wire logic           start,
	output logic                flag,
	output logic                pulse
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic         run;
	logic         next_run;
	logic         next_flag;
	logic         next_pulse;

	// adv is the slow tick: both modes count slow cycles, never fast ones
	always_comb begin
		next_cnt   = cnt;
		next_run   = run;
		next_flag  = flag;
		next_pulse = 1'b0;
		if (DEB) begin
			if (adv) begin
				if (in == flag) begin
					next_cnt = '0;
				end else if (cnt == LIMIT - W'(1)) begin
					next_cnt  = '0;
					next_flag = in;
				end else begin
					next_cnt = cnt + W'(1);
				end
			end
		end else begin
			if (start) begin
				next_run = 1'b1;
				next_cnt = '0;
			end else if (run && adv) begin
				if (cnt == LIMIT - W'(1)) begin
					next_run   = 1'b0;
					next_pulse = 1'b1;
				end else begin
					next_cnt = cnt + W'(1);
				end
			end
			next_flag = next_run;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt   <= '0;
			run   <= 1'b0;
			flag  <= 1'b0;
			pulse <= 1'b0;
		end else begin
			cnt   <= next_cnt;
			run   <= next_run;
			flag  <= next_flag;
			pulse <= next_pulse;
		end
	end
endmodule : sct_counter

// File: sct_timers.sv
// slow-clock timers, debouncers, power-up mode and clock direction
// ************************************************************
// How it works
// - all timer and debounce counts advance on the free-running 32 kHz slow clock input.
// - autoresume watchdog expires after 918 slow cycles.
// - id change accepted after 56 stable cycles, inside 48 to 64.
// - id_line_pullup_enable or weak pullup enable masks id detection 1136 cycles.
// - during mask, receive command bit 6 reports id grounded.
// - weak select picks weak id_line_pullup_enable, else normal pullup.
// - vbus presence debounced over 459 cycles.
// - dp current source on for 8 cycles.
// - dp voltage source on for 1792 cycles per step.
// - wait 1792 cycles after source off before high current.
// - data contact detect times out after 89400 cycles.
// - weak battery connect counter counts 53084160 cycles.
// - voltage source comparator debounced over 760 cycles.
// - dp and dm single-ended receivers each debounced over 1520 cycles.
// - three aca id comparators debounced over 1520 cycles.
// - ulpi clock pin is an input out of reset.
// - reference clock activity turns ulpi clock pin into output.
// - standard power-up only with cs high, cs_n low, supplies valid.
// - vbus with chip unselected, charge enable pin low and battery good starts charger detection.
// - 3.3 V regulator on whenever chip is enabled.
// - reference frequency 19.2 or 26 MHz chosen by config pin.
// - after standard power-up and pll lock, direction is deasserted.
// - charger power-up keeps internal reset asserted and pll off.
// ************************************************************
`include "sct_params.svh"
module sct_timers #(
	parameter int              W          = `SCT_CNT_W,
	parameter logic [W-1:0]    WKB_CYC    = W'(`SCT_WKB_CYC),
	parameter logic [W-1:0]    DCD_CYC    = W'(`SCT_DCD_CYC),
	parameter int              REF_ACT_W  = 4
) (
	input  wire logic          MCLK_I,
	input  wire logic          RSTN_I,
	input  wire logic          SLOW_CLOCK_I,
	input  wire logic          CS_I,
	input  wire logic          CS_N_I,
	input  wire logic          VBAT_OK_I,
	input  wire logic          VIO_OK_I,
	input  wire logic          VBUS_I,
	input  wire logic          CHRG_EN_N_I,
	input  wire logic          PLL_LOCK_I,
	input  wire logic          REF_CLOCK_IN_I,
	input  wire logic          FREQ_SEL_I,
	input  wire logic          ID_I,
	input  wire logic          ID_LINE_PULLUP_ENABLE_I,
	input  wire logic          ID_WEAK_PULLUP_SELECT_I,
	input  wire logic          ID_WEAK_PULLUP_ENABLE_I,
	input  wire logic          AUTORESUME_START_I,
	input  wire logic          IDP_START_I,
	input  wire logic          VDP_START_I,
	input  wire logic          HICRNT_START_I,
	input  wire logic          DCD_START_I,
	input  wire logic          WKB_START_I,
	input  wire logic          ACA_START_I,
	input  wire logic          VDM_CMP_I,
	input  wire logic          SERX_DP_I,
	input  wire logic          SERX_DM_I,
	input  wire logic [2:0]    ACA_ID_CMP_I,
	output logic               AUTORESUME_TIMEOUT_O,
	output logic               ID_DEBOUNCED_O,
	output logic               RXCMD_ID_O,
	output logic               ID_MASK_ACTIVE_O,
	output logic               ID_LINE_PULLUP_ENABLE_NORMAL_O,
	output logic               ID_LINE_PULLUP_ENABLE_WEAK_O,
	output logic               VBUS_DEBOUNCED_O,
	output logic               IDP_SRC_ON_O,
	output logic               VDP_SRC_ON_O,
	output logic               HICRNT_READY_O,
	output logic               DCD_TIMEOUT_O,
	output logic               WEAK_BATTERY_CONNECT_O,
	output logic               VOLTAGE_SOURCE_CMP_DEBOUNCED_O,
	output logic               DP_SINGLE_ENDED_DEBOUNCED_O,
	output logic               DM_SINGLE_ENDED_DEBOUNCED_O,
	output logic [2:0]         ACA_ID_CMP_DEBOUNCED_O,
	output logic               ACA_SETUP_DONE_O,
	output logic               ULPI_CLK_OE_O,
	output logic               REF_FREQ_26M_O,
	output logic               THREE_VOLT_REGULATOR_ON_O,
	output logic               PLL_ENABLE_O,
	output logic               INTERNAL_RESET_N_O,
	output logic               DIR_O,
	output logic               CHARGER_FSM_ENABLE_O
);
	// ************************************************************
	// slow clock edge detect
	// ************************************************************
	logic slow_s1, slow_s2, slow_d;
	logic next_slow_s1, next_slow_s2, next_slow_d;
	logic tick;
	assign tick = slow_s2 & ~slow_d;
	always_comb begin
		next_slow_s1 = SLOW_CLOCK_I;
		next_slow_s2 = slow_s1;
		next_slow_d  = slow_s2;
	end
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			slow_d  <= 1'b0;
		end else begin
			slow_s1 <= next_slow_s1;
			slow_s2 <= next_slow_s2;
			slow_d  <= next_slow_d;
		end
	end

	// ************************************************************
	// start requests held until the next slow tick
	// ************************************************************
	localparam int NS = 8;
	logic [NS-1:0] req, next_req, go;
	logic          pu_rise;
	logic [NS-1:0] ev;
	assign ev = {pu_rise, ACA_START_I, WKB_START_I, DCD_START_I, HICRNT_START_I,
		VDP_START_I, IDP_START_I, AUTORESUME_START_I};
	assign go = tick ? (req | ev) : '0;
	always_comb begin
		next_req = tick ? '0 : (req | ev);
	end
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			req <= '0;
		end else begin
			req <= next_req;
		end
	end

	// ************************************************************
	// timer and debounce instances on the slow tick
	// ************************************************************
	localparam int NT = 8;
	logic [NT-1:0] t_flag, t_pulse;
	logic [6:0]    d_flag;
	logic [6:0]    d_in;
	logic          pu_en, pu_en_d;
	assign pu_en   = ID_LINE_PULLUP_ENABLE_I | ID_WEAK_PULLUP_ENABLE_I;
	assign pu_rise = pu_en & ~pu_en_d;
	assign d_in    = {ACA_ID_CMP_I, SERX_DM_I, SERX_DP_I, VDM_CMP_I, VBUS_I};

	sct_counter #(.W(W), .LIMIT(W'(`SCT_AUTORESUME_CYC))) u_ares (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[0]), .flag(t_flag[0]), .pulse(t_pulse[0]));
	sct_counter #(.W(W), .LIMIT(W'(`SCT_IDP_ON_CYC))) u_idp (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[1]), .flag(t_flag[1]), .pulse(t_pulse[1]));
	sct_counter #(.W(W), .LIMIT(W'(`SCT_VDP_ON_CYC))) u_vdp (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[2]), .flag(t_flag[2]), .pulse(t_pulse[2]));
	sct_counter #(.W(W), .LIMIT(W'(`SCT_HICRNT_CYC))) u_hic (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[3]), .flag(t_flag[3]), .pulse(t_pulse[3]));
	sct_counter #(.W(W), .LIMIT(DCD_CYC)) u_dcd (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[4]), .flag(t_flag[4]), .pulse(t_pulse[4]));
	sct_counter #(.W(W), .LIMIT(WKB_CYC)) u_wkb (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[5]), .flag(t_flag[5]), .pulse(t_pulse[5]));
	sct_counter #(.W(W), .LIMIT(W'(`SCT_ACA_SETUP_CYC))) u_aca (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[6]), .flag(t_flag[6]), .pulse(t_pulse[6]));
	sct_counter #(.W(W), .LIMIT(W'(`SCT_ID_MASK_CYC))) u_mask (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(1'b0), .start(go[7]), .flag(t_flag[7]), .pulse(t_pulse[7]));

	// debouncers count slow ticks: the sampled input only moves on a tick
	logic [6:0] d_smp, next_d_smp;
	logic       id_smp, next_id_smp, id_deb;
	always_comb begin
		next_d_smp  = tick ? d_in : d_smp;
		next_id_smp = tick ? ID_I : id_smp;
	end
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_deb
			localparam logic [W-1:0] LIM = (g == 0) ? W'(`SCT_VBUS_DEB_CYC) :
				(g == 1) ? W'(`SCT_VDM_DEB_CYC) :
				(g <= 3) ? W'(`SCT_SERX_DEB_CYC) : W'(`SCT_ACA_DEB_CYC);
			sct_counter #(.W(W), .LIMIT(LIM), .DEB(1'b1)) u_deb (.clk(MCLK_I),
				.rst_n(RSTN_I), .adv(tick), .in(d_smp[g]), .start(1'b0),
				.flag(d_flag[g]), .pulse());
		end
	endgenerate
	sct_counter #(.W(W), .LIMIT(W'(`SCT_ID_DEB_CYC)), .DEB(1'b1)) u_iddeb (.clk(MCLK_I),
		.rst_n(RSTN_I), .adv(tick), .in(id_smp), .start(1'b0),
		.flag(id_deb), .pulse());

	// ************************************************************
	// power-up mode and clock direction
	// ************************************************************
	sct_pkg::sct_pwr_t pwr, next_pwr;
	logic ref_s1, ref_s2, ref_d;
	logic [REF_ACT_W-1:0] ref_edges, next_ref_edges;
	logic clk_oe, next_clk_oe;
	logic std_ok, chg_ok;
	assign std_ok = CS_I & ~CS_N_I & VBAT_OK_I & VIO_OK_I;
	assign chg_ok = ~(CS_I & ~CS_N_I) & VBUS_I & ~CHRG_EN_N_I & VBAT_OK_I;
	always_comb begin
		next_pwr = pwr;
		case (pwr)
			sct_pkg::SCT_OFF: begin
				if (std_ok) next_pwr = sct_pkg::SCT_STANDARD;
				else if (chg_ok) next_pwr = sct_pkg::SCT_CHARGER;
			end
			sct_pkg::SCT_STANDARD: begin
				if (!std_ok) next_pwr = sct_pkg::SCT_OFF;
			end
			sct_pkg::SCT_CHARGER: begin
				if (std_ok) next_pwr = sct_pkg::SCT_STANDARD;
				else if (!chg_ok) next_pwr = sct_pkg::SCT_OFF;
			end
			default: next_pwr = sct_pkg::SCT_OFF;
		endcase
		next_ref_edges = ref_edges;
		next_clk_oe    = clk_oe;
		if (ref_s2 & ~ref_d & ~(&ref_edges)) begin
			next_ref_edges = ref_edges + REF_ACT_W'(1);
		end
		if (&ref_edges) begin
			next_clk_oe = 1'b1;
		end
	end
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pwr       <= sct_pkg::SCT_OFF;
			ref_s1    <= 1'b0;
			ref_s2    <= 1'b0;
			ref_d     <= 1'b0;
			ref_edges <= '0;
			clk_oe    <= 1'b0;
			pu_en_d   <= 1'b0;
			d_smp     <= '0;
			id_smp    <= 1'b0;
		end else begin
			pwr       <= next_pwr;
			ref_s1    <= REF_CLOCK_IN_I;
			ref_s2    <= ref_s1;
			ref_d     <= ref_s2;
			ref_edges <= next_ref_edges;
			clk_oe    <= next_clk_oe;
			pu_en_d   <= pu_en;
			d_smp     <= next_d_smp;
			id_smp    <= next_id_smp;
		end
	end

	// ************************************************************
	// output registers
	// ************************************************************
	always_ff @(posedge MCLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			AUTORESUME_TIMEOUT_O           <= 1'b0;
			ID_DEBOUNCED_O                 <= 1'b0;
			RXCMD_ID_O                     <= 1'b0;
			ID_MASK_ACTIVE_O               <= 1'b0;
			ID_LINE_PULLUP_ENABLE_NORMAL_O             <= 1'b0;
			ID_LINE_PULLUP_ENABLE_WEAK_O               <= 1'b0;
			VBUS_DEBOUNCED_O               <= 1'b0;
			IDP_SRC_ON_O                   <= 1'b0;
			VDP_SRC_ON_O                   <= 1'b0;
			HICRNT_READY_O                 <= 1'b0;
			DCD_TIMEOUT_O                  <= 1'b0;
			WEAK_BATTERY_CONNECT_O         <= 1'b0;
			VOLTAGE_SOURCE_CMP_DEBOUNCED_O <= 1'b0;
			DP_SINGLE_ENDED_DEBOUNCED_O    <= 1'b0;
			DM_SINGLE_ENDED_DEBOUNCED_O    <= 1'b0;
			ACA_ID_CMP_DEBOUNCED_O         <= '0;
			ACA_SETUP_DONE_O               <= 1'b0;
			ULPI_CLK_OE_O                  <= 1'b0;
			REF_FREQ_26M_O                 <= 1'b0;
			THREE_VOLT_REGULATOR_ON_O                    <= 1'b0;
			PLL_ENABLE_O                   <= 1'b0;
			INTERNAL_RESET_N_O             <= 1'b0;
			DIR_O                          <= 1'b1;
			CHARGER_FSM_ENABLE_O           <= 1'b0;
		end else begin
			AUTORESUME_TIMEOUT_O           <= t_pulse[0];
			ID_DEBOUNCED_O                 <= id_deb;
			RXCMD_ID_O                     <= t_flag[7] ? 1'b0 : id_deb;
			ID_MASK_ACTIVE_O               <= t_flag[7];
			ID_LINE_PULLUP_ENABLE_NORMAL_O             <= ID_LINE_PULLUP_ENABLE_I & ~ID_WEAK_PULLUP_SELECT_I;
			ID_LINE_PULLUP_ENABLE_WEAK_O               <= ID_LINE_PULLUP_ENABLE_I & ID_WEAK_PULLUP_SELECT_I;
			VBUS_DEBOUNCED_O               <= d_flag[0];
			IDP_SRC_ON_O                   <= t_flag[1];
			VDP_SRC_ON_O                   <= t_flag[2];
			HICRNT_READY_O                 <= t_pulse[3];
			DCD_TIMEOUT_O                  <= t_pulse[4];
			WEAK_BATTERY_CONNECT_O         <= t_pulse[5];
			VOLTAGE_SOURCE_CMP_DEBOUNCED_O <= d_flag[1];
			DP_SINGLE_ENDED_DEBOUNCED_O    <= d_flag[2];
			DM_SINGLE_ENDED_DEBOUNCED_O    <= d_flag[3];
			ACA_ID_CMP_DEBOUNCED_O         <= d_flag[6:4];
			ACA_SETUP_DONE_O               <= t_pulse[6];
			ULPI_CLK_OE_O                  <= clk_oe;
			REF_FREQ_26M_O                 <= FREQ_SEL_I;
			THREE_VOLT_REGULATOR_ON_O                    <= (pwr != sct_pkg::SCT_OFF);
			PLL_ENABLE_O                   <= (pwr == sct_pkg::SCT_STANDARD);
			INTERNAL_RESET_N_O             <= (pwr == sct_pkg::SCT_STANDARD);
			DIR_O                          <= ~((pwr == sct_pkg::SCT_STANDARD) & PLL_LOCK_I);
			CHARGER_FSM_ENABLE_O           <= (pwr == sct_pkg::SCT_CHARGER);
		end
	end
endmodule : sct_timers

// File: sct_timers_monitor.sv
// assertion checker of the slow-clock timer block ports
// ********
// checker
// ********
module sct_timers_monitor (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic CS_I,
	input wire logic CS_N_I,
	input wire logic VBAT_OK_I,
	input wire logic VIO_OK_I,
	input wire logic AUTORESUME_TIMEOUT_O,
	input wire logic RXCMD_ID_O,
	input wire logic ID_MASK_ACTIVE_O,
	input wire logic ID_LINE_PULLUP_ENABLE_NORMAL_O,
	input wire logic ID_LINE_PULLUP_ENABLE_WEAK_O,
	input wire logic IDP_SRC_ON_O,
	input wire logic HICRNT_READY_O,
	input wire logic ULPI_CLK_OE_O,
	input wire logic THREE_VOLT_REGULATOR_ON_O,
	input wire logic PLL_ENABLE_O,
	input wire logic INTERNAL_RESET_N_O,
	input wire logic DIR_O,
	input wire logic CHARGER_FSM_ENABLE_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge MCLK_I); endclocking
	default disable iff (!RSTN_I);
	mask_rxcmd_a: assert property (ID_MASK_ACTIVE_O |-> !RXCMD_ID_O)
		else $error("id not grounded while masked");
	pull_excl_a: assert property (!(ID_LINE_PULLUP_ENABLE_NORMAL_O && ID_LINE_PULLUP_ENABLE_WEAK_O))
		else $error("both id pullups on");
	ar_pulse_a: assert property ($rose(AUTORESUME_TIMEOUT_O) |=> !AUTORESUME_TIMEOUT_O)
		else $error("autoresume expiry too long");
	hicrnt_pulse_a: assert property (HICRNT_READY_O |=> $fell(HICRNT_READY_O))
		else $error("high current ready too long");
	idp_hold_a: assert property ($rose(IDP_SRC_ON_O) |-> IDP_SRC_ON_O[*8])
		else $error("current source dropped early");
	clk_oe_keep_a: assert property (ULPI_CLK_OE_O |=> ULPI_CLK_OE_O)
		else $error("clock output dropped");
	reg_on_a: assert property ((CS_I && !CS_N_I && VBAT_OK_I && VIO_OK_I)[*8] |-> THREE_VOLT_REGULATOR_ON_O)
		else $error("regulator off while enabled");
	no_std_a: assert property ((!CS_I || CS_N_I)[*8] |-> !PLL_ENABLE_O)
		else $error("pll on while unselected");
	chg_hold_a: assert property (CHARGER_FSM_ENABLE_O |-> !PLL_ENABLE_O && !INTERNAL_RESET_N_O)
		else $error("charger mode left reset or pll");
	dir_fall_a: assert property ($fell(DIR_O) |-> PLL_ENABLE_O && INTERNAL_RESET_N_O)
		else $error("direction fell outside standard mode");
	cover property ($rose(ULPI_CLK_OE_O));
	cover property ($fell(DIR_O));
	cover property ($rose(ID_MASK_ACTIVE_O));
endmodule : sct_timers_monitor
bind sct_timers sct_timers_monitor sct_timers_monitor_i (.MCLK_I, .RSTN_I, .CS_I, .CS_N_I,
	.VBAT_OK_I, .VIO_OK_I, .AUTORESUME_TIMEOUT_O, .RXCMD_ID_O, .ID_MASK_ACTIVE_O,
	.ID_LINE_PULLUP_ENABLE_NORMAL_O, .ID_LINE_PULLUP_ENABLE_WEAK_O, .IDP_SRC_ON_O, .HICRNT_READY_O, .ULPI_CLK_OE_O,
	.THREE_VOLT_REGULATOR_ON_O, .PLL_ENABLE_O, .INTERNAL_RESET_N_O, .DIR_O, .CHARGER_FSM_ENABLE_O);

// File: sct_sys_model.sv
// system clock source facing the block: reference clock and frequency select
module sct_sys_model (
	input  wire logic clk,
	input  wire logic ref_on,
	input  wire logic fsel_req,
	output logic      ref_clk,
	output logic      freq_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic div = 1'b0;
	always @(posedge clk) begin
		div <= ~div;
		freq_sel <= fsel_req;
		if (!ref_on) begin
			ref_clk <= 1'b0;
		end else if (div) begin
			ref_clk <= ~ref_clk;
		end
	end
endmodule : sct_sys_model

// File: sct_timers_tb.sv
// self-checking testbench of the slow-clock timer block
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t mismatch %0h %0h", $time, (a), (b)); end end
module sct_timers_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// signals
	// ********
	logic MCLK_I = 1'b0, RSTN_I, SLOW_CLOCK_I, CS_I, CS_N_I, VBAT_OK_I, VIO_OK_I;
	logic CHRG_EN_N_I, PLL_LOCK_I, ID_WEAK_PULLUP_SELECT_I, ref_on, fsel_req;
	logic [8:0] stq;
	logic [7:0] din;
	logic [2:0] ph = 3'h0;
	int n_tick = 0, n_fail = 0, samples_checked = 0;
	wire REF_CLOCK_IN_I, FREQ_SEL_I, ID_I, ID_LINE_PULLUP_ENABLE_I, ID_WEAK_PULLUP_ENABLE_I;
	wire AUTORESUME_START_I, IDP_START_I, VDP_START_I, HICRNT_START_I, DCD_START_I;
	wire WKB_START_I, ACA_START_I, VDM_CMP_I, SERX_DP_I, SERX_DM_I, AUTORESUME_TIMEOUT_O;
	wire VBUS_I;
	wire ID_DEBOUNCED_O, RXCMD_ID_O, ID_MASK_ACTIVE_O, ID_LINE_PULLUP_ENABLE_NORMAL_O, ID_LINE_PULLUP_ENABLE_WEAK_O;
	wire VBUS_DEBOUNCED_O, IDP_SRC_ON_O, VDP_SRC_ON_O, HICRNT_READY_O, DCD_TIMEOUT_O;
	wire WEAK_BATTERY_CONNECT_O, VOLTAGE_SOURCE_CMP_DEBOUNCED_O, DP_SINGLE_ENDED_DEBOUNCED_O;
	wire DM_SINGLE_ENDED_DEBOUNCED_O, ACA_SETUP_DONE_O, ULPI_CLK_OE_O, REF_FREQ_26M_O;
	wire THREE_VOLT_REGULATOR_ON_O, PLL_ENABLE_O, INTERNAL_RESET_N_O, DIR_O, CHARGER_FSM_ENABLE_O;
	wire [2:0] ACA_ID_CMP_I, ACA_ID_CMP_DEBOUNCED_O;
	wire [8:0] outs;
	wire [7:0] dflg;
	assign {ID_WEAK_PULLUP_ENABLE_I, ID_LINE_PULLUP_ENABLE_I, ACA_START_I, WKB_START_I,
		DCD_START_I, HICRNT_START_I, VDP_START_I, IDP_START_I, AUTORESUME_START_I} = stq;
	assign outs = {ID_MASK_ACTIVE_O, ID_MASK_ACTIVE_O, ACA_SETUP_DONE_O, WEAK_BATTERY_CONNECT_O,
		DCD_TIMEOUT_O, HICRNT_READY_O, VDP_SRC_ON_O, IDP_SRC_ON_O, AUTORESUME_TIMEOUT_O};
	assign {ACA_ID_CMP_I, SERX_DM_I, SERX_DP_I, VDM_CMP_I, VBUS_I, ID_I} = din;
	assign dflg = {ACA_ID_CMP_DEBOUNCED_O, DM_SINGLE_ENDED_DEBOUNCED_O,
		DP_SINGLE_ENDED_DEBOUNCED_O, VOLTAGE_SOURCE_CMP_DEBOUNCED_O, VBUS_DEBOUNCED_O,
		ID_DEBOUNCED_O};
	// ********
	// clocks, design and partner
	// ********
	always #2 MCLK_I = ~MCLK_I;
	always @(posedge MCLK_I) begin
		ph <= ph + 3'h1;
		SLOW_CLOCK_I <= (ph == 3'h7) || (ph < 3'h3);
		if (ph == 3'h7) begin
			n_tick <= n_tick + 1;
		end
	end
	sct_timers #(.WKB_CYC(26'h14), .DCD_CYC(26'h14)) sct_timers_i (.MCLK_I, .RSTN_I,
		.SLOW_CLOCK_I, .CS_I, .CS_N_I, .VBAT_OK_I, .VIO_OK_I, .VBUS_I, .CHRG_EN_N_I,
		.PLL_LOCK_I, .REF_CLOCK_IN_I, .FREQ_SEL_I, .ID_I, .ID_LINE_PULLUP_ENABLE_I,
		.ID_WEAK_PULLUP_SELECT_I, .ID_WEAK_PULLUP_ENABLE_I, .AUTORESUME_START_I, .IDP_START_I,
		.VDP_START_I, .HICRNT_START_I, .DCD_START_I, .WKB_START_I, .ACA_START_I, .VDM_CMP_I,
		.SERX_DP_I, .SERX_DM_I, .ACA_ID_CMP_I, .AUTORESUME_TIMEOUT_O, .ID_DEBOUNCED_O,
		.RXCMD_ID_O, .ID_MASK_ACTIVE_O, .ID_LINE_PULLUP_ENABLE_NORMAL_O, .ID_LINE_PULLUP_ENABLE_WEAK_O,
		.VBUS_DEBOUNCED_O, .IDP_SRC_ON_O, .VDP_SRC_ON_O, .HICRNT_READY_O, .DCD_TIMEOUT_O,
		.WEAK_BATTERY_CONNECT_O, .VOLTAGE_SOURCE_CMP_DEBOUNCED_O, .DP_SINGLE_ENDED_DEBOUNCED_O,
		.DM_SINGLE_ENDED_DEBOUNCED_O, .ACA_ID_CMP_DEBOUNCED_O, .ACA_SETUP_DONE_O,
		.ULPI_CLK_OE_O, .REF_FREQ_26M_O, .THREE_VOLT_REGULATOR_ON_O, .PLL_ENABLE_O, .INTERNAL_RESET_N_O,
		.DIR_O, .CHARGER_FSM_ENABLE_O);
	sct_sys_model sct_sys_model_i (.clk(MCLK_I), .ref_on(ref_on), .fsel_req(fsel_req),
		.ref_clk(REF_CLOCK_IN_I), .freq_sel(FREQ_SEL_I));
	// ********
	// tasks
	// ********
	task automatic wrap_up();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic guard(input int k, input int m);
		if (k >= m) begin
			n_fail++;
			wrap_up();
		end
	endtask : guard
	task automatic cyc(input int n);
		repeat (n) @(negedge MCLK_I);
	endtask : cyc
	// lines up on a fixed slow phase so the next tick takes the request
	task automatic sync4();
		int k;
		k = 0;
		while (ph != 3'h4 && k < 9) begin
			@(negedge MCLK_I);
			k++;
		end
		guard(k, 9);
		@(posedge MCLK_I);
	endtask : sync4
	task automatic run_t(input int s, input int n, input bit lvl);
		int t0;
		int k;
		sync4();
		stq[s] <= 1'b1;
		t0 = n_tick;
		@(posedge MCLK_I);
		stq[s] <= 1'b0;
		k = 0;
		while (outs[s] !== 1'b1 && k < 8 * n + 80) begin
			@(negedge MCLK_I);
			k++;
		end
		while (lvl && outs[s] === 1'b1 && k < 8 * n + 80) begin
			@(negedge MCLK_I);
			k++;
		end
		guard(k, 8 * n + 80);
		`CHK(n_tick - t0, n + 1)
		if (!lvl) begin
			@(negedge MCLK_I);
			`CHK(outs[s], 1'b0)
		end
	endtask : run_t
	task automatic deb(input logic [7:0] v, input int n);
		int t0;
		int k;
		sync4();
		din <= v;
		t0 = n_tick;
		k = 0;
		while (dflg !== v && k < 8 * n + 80) begin
			@(negedge MCLK_I);
			k++;
		end
		guard(k, 8 * n + 80);
		`CHK((n_tick - t0 == n) || (n_tick - t0 == n + 1), 1'b1)
	endtask : deb
	// ********
	// sequence
	// ********
	initial begin
		RSTN_I = 1'b0;
		CS_I = 1'b0;
		CS_N_I = 1'b1;
		VBAT_OK_I = 1'b1;
		VIO_OK_I = 1'b1;
		CHRG_EN_N_I = 1'b0;
		PLL_LOCK_I = 1'b0;
		ID_WEAK_PULLUP_SELECT_I = 1'b0;
		ref_on = 1'b0;
		fsel_req = 1'b0;
		stq = 9'h000;
		din = 8'h00;
		repeat (3) @(posedge MCLK_I);
		RSTN_I <= 1'b1;
		cyc(1);
		`CHK(DIR_O, 1'b1)
		`CHK(ULPI_CLK_OE_O, 1'b0)
		deb(8'h01, 56);
		sync4();
		din[0] <= 1'b0;
		repeat (319) @(posedge MCLK_I);
		cyc(1);
		`CHK(ID_DEBOUNCED_O, 1'b1)
		@(posedge MCLK_I);
		din[0] <= 1'b1;
		cyc(320);
		`CHK(ID_DEBOUNCED_O, 1'b1)
		`CHK(RXCMD_ID_O, 1'b1)
		deb(8'h03, 459);
		cyc(10);
		`CHK(CHARGER_FSM_ENABLE_O, 1'b1)
		`CHK(INTERNAL_RESET_N_O, 1'b0)
		@(posedge MCLK_I);
		CS_I <= 1'b1;
		cyc(10);
		`CHK(PLL_ENABLE_O, 1'b0)
		@(posedge MCLK_I);
		CS_N_I <= 1'b0;
		cyc(10);
		`CHK(THREE_VOLT_REGULATOR_ON_O, 1'b1)
		`CHK(INTERNAL_RESET_N_O, 1'b1)
		`CHK(PLL_ENABLE_O, 1'b1)
		`CHK(DIR_O, 1'b1)
		@(posedge MCLK_I);
		PLL_LOCK_I <= 1'b1;
		cyc(10);
		`CHK(DIR_O, 1'b0)
		deb(8'h07, 760);
		deb(8'hFF, 1520);
		@(posedge MCLK_I);
		ref_on <= 1'b1;
		fsel_req <= 1'b1;
		cyc(200);
		`CHK(ULPI_CLK_OE_O, 1'b1)
		`CHK(REF_FREQ_26M_O, 1'b1)
		@(posedge MCLK_I);
		fsel_req <= 1'b0;
		cyc(10);
		`CHK(REF_FREQ_26M_O, 1'b0)
		run_t(7, 1136, 1'b1);
		run_t(8, 1136, 1'b1);
		@(posedge MCLK_I);
		stq[7] <= 1'b1;
		cyc(10);
		`CHK({ID_LINE_PULLUP_ENABLE_NORMAL_O, ID_LINE_PULLUP_ENABLE_WEAK_O}, 2'h2)
		`CHK({ID_MASK_ACTIVE_O, RXCMD_ID_O}, 2'h2)
		@(posedge MCLK_I);
		ID_WEAK_PULLUP_SELECT_I <= 1'b1;
		cyc(10);
		`CHK({ID_LINE_PULLUP_ENABLE_NORMAL_O, ID_LINE_PULLUP_ENABLE_WEAK_O}, 2'h1)
		@(posedge MCLK_I);
		stq[7] <= 1'b0;
		run_t(0, 918, 1'b0);
		run_t(1, 8, 1'b1);
		run_t(2, 1792, 1'b1);
		run_t(3, 1792, 1'b0);
		run_t(4, 20, 1'b0);
		run_t(5, 20, 1'b0);
		run_t(6, 2300, 1'b0);
		wrap_up();
	end
endmodule : sct_timers_tb
